// [rtl/t3fp_cfg.svh]
// Offsets, field positions, reset values and tap widths of the timer3 flag block
`ifndef T3FP_CFG_SVH
`define T3FP_CFG_SVH

// ****************************************************************
// Address map (data-space offsets)
// ****************************************************************
`define T3FP_IO_BASE       12'h020
`define T3FP_EXT_BASE      12'h060
`define T3FP_OFS_FLAGS     12'h038
`define T3FP_OFS_MASK      12'h071
`define T3FP_OFS_GTCTRL    12'h043
`define T3FP_OFS_CMPB_LO   12'h0A0
`define T3FP_OFS_CMPB_HI   12'h0A1

// ****************************************************************
// Field positions
// ****************************************************************
`define T3FP_BIT_CAPT      5
`define T3FP_BIT_CMPB      2
`define T3FP_BIT_CMPA      1
`define T3FP_BIT_OVF       0
`define T3FP_BIT_SYNC      7
`define T3FP_BIT_PSR       0
`define T3FP_FLAG_MASK     8'h27

// ****************************************************************
// Reset values
// ****************************************************************
`define T3FP_RST_FLAGS     8'h00
`define T3FP_RST_MASK      8'h00
`define T3FP_RST_CMPB      16'h0000

// ****************************************************************
// Prescaler: counter width and tap widths (divide by 2**n)
// ****************************************************************
`define T3FP_PS_WIDTH      10
`define T3FP_TAP8_BITS     3
`define T3FP_TAP64_BITS    6
`define T3FP_TAP256_BITS   8
`define T3FP_TAP1024_BITS  10

// ****************************************************************
// Waveform mode codes that count plain overflow
// ****************************************************************
`define T3FP_WAVE_NORMAL   4'h0
`define T3FP_WAVE_CTC_A    4'h4
`define T3FP_WAVE_CTC_CAPT 4'hC

`endif

// [rtl/t3fp_pkg.sv]
// Types shared by the timer3 flag block and the shared prescaler
package t3fp_pkg;

    // Clock select codes of one timer
    typedef enum logic [2:0] {
        T3FP_CS_STOP  = 3'h0,
        T3FP_CS_SYS   = 3'h1,
        T3FP_CS_DIV8  = 3'h2,
        T3FP_CS_DIV64 = 3'h3,
        T3FP_CS_DIV256 = 3'h4,
        T3FP_CS_DIV1024 = 3'h5,
        T3FP_CS_EXTFALL = 3'h6,
        T3FP_CS_EXTRISE = 3'h7
    } t3fp_clksel_type;

    typedef logic [3:0] t3fp_taps_type;

endpackage

// [rtl/t3fp_prescaler.sv]
// Shared free-running prescaler and external count pin sampling
`timescale 1ns/10ps
`include "t3fp_cfg.svh"
module t3fp_prescaler
    import t3fp_pkg::*;
#(
    parameter int NT = 3
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [NT-1:0] extCountPin,
    t3fp_tick_if.prescaler     tk
);

    logic [`T3FP_PS_WIDTH-1:0] psCount_r;
    logic [`T3FP_PS_WIDTH-1:0] psCount_nxt;
    logic [NT-1:0]             pinLatch;
    logic [NT-1:0]             pinSync_r;
    logic [NT-1:0]             pinPrev_r;
    t3fp_taps_type             tapPulse;
    logic [NT-1:0]             riseEdge;
    logic [NT-1:0]             fallEdge;

    function automatic logic tapDone(input logic [`T3FP_PS_WIDTH-1:0] cnt, input int bits);
        logic [`T3FP_PS_WIDTH-1:0] msk;
        msk = `T3FP_PS_WIDTH'((1 << bits) - 1);
        return (cnt & msk) == msk;
    endfunction

    // ****************************************************************
    // Prescaler counter
    // ****************************************************************
    // free running divider
    always_comb begin
        psCount_nxt = tk.prescalerReset ? '0 : psCount_r + `T3FP_PS_WIDTH'(1);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            psCount_r <= '0;
        end else begin
            psCount_r <= psCount_nxt;
        end
    end

    always_comb begin
        tapPulse[0] = tapDone(psCount_r, `T3FP_TAP8_BITS) && !tk.prescalerReset;
        tapPulse[1] = tapDone(psCount_r, `T3FP_TAP64_BITS) && !tk.prescalerReset;
        tapPulse[2] = tapDone(psCount_r, `T3FP_TAP256_BITS) && !tk.prescalerReset;
        tapPulse[3] = tapDone(psCount_r, `T3FP_TAP1024_BITS) && !tk.prescalerReset;
    end

    // ****************************************************************
    // External pin sampling
    // ****************************************************************
    // latch open while clock high
    always_latch begin
        if (clk) begin
            pinLatch <= extCountPin;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinSync_r <= '0;
            pinPrev_r <= '0;
        end else begin
            pinSync_r <= pinLatch;
            pinPrev_r <= pinSync_r;
        end
    end

    assign riseEdge = pinSync_r & ~pinPrev_r;
    assign fallEdge = ~pinSync_r & pinPrev_r;

    // ****************************************************************
    // Clock select per timer
    // ****************************************************************
    // Held prescaler reset halts every timer, external clock included
    always_comb begin
        for (int i = 0; i < NT; i++) begin
            tk.timerTick[i] = 1'b0;
            if (!tk.prescalerReset) begin
                unique case (tk.clockSel[i])
                    T3FP_CS_STOP:    tk.timerTick[i] = 1'b0;
                    T3FP_CS_SYS:     tk.timerTick[i] = 1'b1;
                    T3FP_CS_DIV8:    tk.timerTick[i] = tapPulse[0];
                    T3FP_CS_DIV64:   tk.timerTick[i] = tapPulse[1];
                    T3FP_CS_DIV256:  tk.timerTick[i] = tapPulse[2];
                    T3FP_CS_DIV1024: tk.timerTick[i] = tapPulse[3];
                    T3FP_CS_EXTFALL: tk.timerTick[i] = fallEdge[i];
                    T3FP_CS_EXTRISE: tk.timerTick[i] = riseEdge[i];
                endcase
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    tap8_period_a: assert property (tapPulse[0] ##1 (!tk.prescalerReset)[*8] |-> tapPulse[0])
        else $error("divide by 8 tap lost its period");
    halt_ticks_a: assert property (tk.prescalerReset |-> tk.timerTick == '0)
        else $error("timer ticked while prescaler held");
    ext_rise_a: assert property ((tk.clockSel[NT-1] == T3FP_CS_EXTRISE)
        && !tk.prescalerReset && $rose(pinSync_r[NT-1]) |-> tk.timerTick[NT-1])
        else $error("rising edge on count pin gave no tick");

endmodule

// [rtl/t3fp_tick_if.sv]
// Link between the flag block and the shared prescaler
`timescale 1ns/10ps
interface t3fp_tick_if #(parameter int NT = 3);
    import t3fp_pkg::*;
    t3fp_clksel_type clockSel [NT];
    logic            prescalerReset;
    logic [NT-1:0]   timerTick;

    modport owner     (output clockSel, output prescalerReset, input timerTick);
    modport prescaler (input clockSel, input prescalerReset, output timerTick);
endinterface

// [rtl/t3fp_timer_flags.sv]
// Timer3 event flags, irq mask, compare B value and shared prescaler control
`timescale 1ns/10ps
`include "t3fp_cfg.svh"
module t3fp_timer_flags
    import t3fp_pkg::*;
#(
    parameter int NT = 3,
    parameter int CW = 16
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [11:0]   busAddr,
    input  wire logic          busIoSpace,
    input  wire logic          busWrite,
    input  wire logic          busRead,
    input  wire logic [7:0]    busWdata,
    output logic      [7:0]    busRdata,
    input  wire logic          globalIrqEnable,
    input  wire logic [3:0]    vectorAck,
    output logic      [3:0]    irqRequest,
    input  wire logic [2:0]    clockSel0,
    input  wire logic [2:0]    clockSel1,
    input  wire logic [2:0]    clockSel3,
    input  wire logic [NT-1:0] extCountPin,
    output logic      [NT-1:0] timerTick,
    input  wire logic [CW-1:0] countValue,
    input  wire logic [CW-1:0] compareAValue,
    input  wire logic [3:0]    waveformModeBits,
    input  wire logic          countOverflow,
    input  wire logic          countAtTop,
    input  wire logic          waveOverflowEvent,
    input  wire logic          capturePinEvent,
    input  wire logic          forceCompareAStrobe,
    input  wire logic          forceCompareBStrobe,
    output logic      [CW-1:0] compareBValue,
    output logic               compareBMatch,
    output logic               compareAMatch
);

    t3fp_tick_if #(.NT(NT)) tk ();

    logic [7:0]    flags_r;
    logic [7:0]    flags_nxt;
    logic [7:0]    mask_r;
    logic [7:0]    mask_nxt;
    logic [7:0]    temp_r;
    logic [7:0]    temp_nxt;
    logic [CW-1:0] cmpB_r;
    logic [CW-1:0] cmpB_nxt;
    logic          syncMode_r;
    logic          syncMode_nxt;
    logic          psr_r;
    logic          psr_nxt;
    logic          psrPulse_r;
    logic          psrPulse_nxt;
    logic [7:0]    rdata_r;
    logic [7:0]    rdata_nxt;
    logic [11:0]   effAddr;
    logic          tick3;
    logic          matchB;
    logic          matchA;
    logic [7:0]    setEvt;
    logic [7:0]    clrEvt;

    // Maps an access to its data-space offset; 0xFFF marks unreachable
    function automatic logic [11:0] dataOffset(input logic [11:0] addr, input logic io);
        logic [11:0] ofs;
        ofs = 12'hFFF;
        if (io) begin
            if (addr < 12'h040) begin
                ofs = addr + `T3FP_IO_BASE;
            end
        end else begin
            ofs = addr;
        end
        return ofs;
    endfunction

    // Waveform modes whose TOP is held in the capture register
    function automatic logic captureIsTop(input logic [3:0] wgm);
        return wgm[3] && !wgm[0];
    endfunction

    // ****************************************************************
    // Shared prescaler
    // ****************************************************************
    assign tk.clockSel[0]      = t3fp_clksel_type'(clockSel0);
    assign tk.clockSel[1]      = t3fp_clksel_type'(clockSel1);
    assign tk.clockSel[NT-1]   = t3fp_clksel_type'(clockSel3);
    // one reset line feeds all timers
    assign tk.prescalerReset   = psr_r || psrPulse_r;
    assign timerTick           = tk.timerTick;
    assign tick3               = tk.timerTick[NT-1];

    t3fp_prescaler #(.NT(NT)) u_prescaler (
        .clk         (clk),
        .rstn        (rstn),
        .extCountPin (extCountPin),
        .tk          (tk.prescaler)
    );

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // I/O window maps to offset plus 0x20
    assign effAddr = dataOffset(busAddr, busIoSpace);

    // ****************************************************************
    // Event detection
    // ****************************************************************
    // compare on every timer tick
    assign matchB = tick3 && (countValue == cmpB_r);
    assign matchA = tick3 && (countValue == compareAValue);
    assign compareBMatch = matchB || forceCompareBStrobe;
    assign compareAMatch = matchA || forceCompareAStrobe;

    always_comb begin
        setEvt = 8'h00;
        setEvt[`T3FP_BIT_CAPT] = captureIsTop(waveformModeBits) ? (tick3 && countAtTop)
                                                                : capturePinEvent;
        setEvt[`T3FP_BIT_CMPB] = matchB;
        setEvt[`T3FP_BIT_CMPA] = matchA;
        if (waveformModeBits == `T3FP_WAVE_NORMAL || waveformModeBits == `T3FP_WAVE_CTC_A
            || waveformModeBits == `T3FP_WAVE_CTC_CAPT) begin
            setEvt[`T3FP_BIT_OVF] = tick3 && countOverflow;
        end else begin
            setEvt[`T3FP_BIT_OVF] = tick3 && waveOverflowEvent;
        end
    end

    // ****************************************************************
    // Event flags
    // ****************************************************************
    always_comb begin
        clrEvt = 8'h00;
        clrEvt[`T3FP_BIT_CAPT] = vectorAck[3];
        clrEvt[`T3FP_BIT_CMPB] = vectorAck[2];
        clrEvt[`T3FP_BIT_CMPA] = vectorAck[1];
        clrEvt[`T3FP_BIT_OVF]  = vectorAck[0];
        if (busWrite && effAddr == `T3FP_OFS_FLAGS) begin
            clrEvt = clrEvt | busWdata;
        end
        // Set beats clear so a same-cycle event is kept
        flags_nxt = ((flags_r & ~clrEvt) | setEvt) & `T3FP_FLAG_MASK;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flags_r <= `T3FP_RST_FLAGS;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ****************************************************************
    // Mask and interrupt request
    // ****************************************************************
    always_comb begin
        mask_nxt = mask_r;
        if (busWrite && effAddr == `T3FP_OFS_MASK) begin
            mask_nxt = busWdata & `T3FP_FLAG_MASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_r <= `T3FP_RST_MASK;
        end else begin
            mask_r <= mask_nxt;
        end
    end

    // enable, global and flag all set
    always_comb begin
        irqRequest[3] = globalIrqEnable && mask_r[`T3FP_BIT_CAPT] && flags_r[`T3FP_BIT_CAPT];
        irqRequest[2] = globalIrqEnable && mask_r[`T3FP_BIT_CMPB] && flags_r[`T3FP_BIT_CMPB];
        irqRequest[1] = globalIrqEnable && mask_r[`T3FP_BIT_CMPA] && flags_r[`T3FP_BIT_CMPA];
        irqRequest[0] = globalIrqEnable && mask_r[`T3FP_BIT_OVF] && flags_r[`T3FP_BIT_OVF];
    end

    // ****************************************************************
    // Compare B value and shared high-byte latch
    // ****************************************************************
    // high byte parks, low byte commits
    always_comb begin
        temp_nxt = temp_r;
        cmpB_nxt = cmpB_r;
        if (busWrite && effAddr == `T3FP_OFS_CMPB_HI) begin
            temp_nxt = busWdata;
        end
        if (busWrite && effAddr == `T3FP_OFS_CMPB_LO) begin
            cmpB_nxt = {temp_r, busWdata};
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            temp_r <= 8'h00;
            cmpB_r <= `T3FP_RST_CMPB;
        end else begin
            temp_r <= temp_nxt;
            cmpB_r <= cmpB_nxt;
        end
    end

    assign compareBValue = cmpB_r;

    // ****************************************************************
    // Prescaler reset and sync mode
    // ****************************************************************
    always_comb begin
        syncMode_nxt = syncMode_r;
        psr_nxt      = psr_r;
        psrPulse_nxt = 1'b0;
        if (busWrite && effAddr == `T3FP_OFS_GTCTRL) begin
            syncMode_nxt = busWdata[`T3FP_BIT_SYNC];
            if (busWdata[`T3FP_BIT_SYNC]) begin
                psr_nxt = psr_r || busWdata[`T3FP_BIT_PSR];
            end else begin
                psr_nxt      = 1'b0;
                psrPulse_nxt = busWdata[`T3FP_BIT_PSR];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncMode_r <= 1'b0;
            psr_r      <= 1'b0;
            psrPulse_r <= 1'b0;
        end else begin
            syncMode_r <= syncMode_nxt;
            psr_r      <= psr_nxt;
            psrPulse_r <= psrPulse_nxt;
        end
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Reads have no side effects; data lands one cycle after the strobe
    always_comb begin
        rdata_nxt = rdata_r;
        if (busRead) begin
            unique case (effAddr)
                `T3FP_OFS_FLAGS:   rdata_nxt = flags_r;
                `T3FP_OFS_MASK:    rdata_nxt = mask_r;
                `T3FP_OFS_GTCTRL:  rdata_nxt = {syncMode_r, 6'h00, psr_r};
                `T3FP_OFS_CMPB_LO: rdata_nxt = cmpB_r[7:0];
                `T3FP_OFS_CMPB_HI: rdata_nxt = cmpB_r[15:8];
                default:           rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign busRdata = rdata_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    cmpb_flag_set_a: assert property (matchB |=> flags_r[`T3FP_BIT_CMPB])
        else $error("compare B match did not set its flag");
    force_no_flag_a: assert property (forceCompareBStrobe && !matchB
        && !flags_r[`T3FP_BIT_CMPB] |=> !flags_r[`T3FP_BIT_CMPB])
        else $error("forced strobe set compare B flag");
    w1c_clear_a: assert property (busWrite && effAddr == `T3FP_OFS_FLAGS
        && busWdata[`T3FP_BIT_OVF] && !setEvt[`T3FP_BIT_OVF] |=> !flags_r[`T3FP_BIT_OVF])
        else $error("written one did not clear overflow flag");
    w0_keep_a: assert property (busWrite && effAddr == `T3FP_OFS_FLAGS
        && !busWdata[`T3FP_BIT_CMPA] && !vectorAck[1] && flags_r[`T3FP_BIT_CMPA]
        |=> flags_r[`T3FP_BIT_CMPA])
        else $error("written zero cleared compare A flag");
    irq_masked_a: assert property (busWrite && effAddr == `T3FP_OFS_MASK
        && !busWdata[`T3FP_BIT_CMPB] |=> !irqRequest[2])
        else $error("masked compare B still requests");
    temp_commit_a: assert property (busWrite && effAddr == `T3FP_OFS_CMPB_HI
        ##1 busWrite && effAddr == `T3FP_OFS_CMPB_LO
        |=> cmpB_r == {$past(busWdata, 2), $past(busWdata)})
        else $error("compare B bytes not committed together");
    io_ext_blocked_a: assert property (busWrite && busIoSpace |=> $stable(mask_r))
        else $error("I/O access reached extended register");
    sync_hold_a: assert property (syncMode_r && psr_r && !busWrite
        |=> psr_r && tk.prescalerReset)
        else $error("held prescaler reset dropped in sync mode");
    psr_selfclr_a: assert property (busWrite && effAddr == `T3FP_OFS_GTCTRL
        && !busWdata[`T3FP_BIT_SYNC] |=> !psr_r
        && psrPulse_r == $past(busWdata[`T3FP_BIT_PSR]))
        else $error("prescaler reset bit did not self-clear");

endmodule

// [tb/t3fp_ext_src.sv]
// Model of the clock source on the timer3 external count pin
`timescale 1ns/10ps
module t3fp_ext_src (
    input  wire logic clk,
    input  wire logic run,
    output logic      pin
);
    logic [1:0] cnt;
    initial begin
        pin = 1'b0;
        cnt = 2'h0;
    end
    // slow source, idle when stopped
    // Halves of three cycles stay clear of the sampling limit
    always @(posedge clk) begin
        if (run) begin
            cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
            if (cnt == 2'h2) begin
                pin <= ~pin;
            end
        end
    end
endmodule

// [tb/tb.sv]
// Self-checking bench of the timer3 flag block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checkCount++; if ((s) !== (e)) begin nErrors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb;
    import t3fp_pkg::*;
    logic clk, rstn, busIoSpace, busWrite, busRead, globalIrqEnable, extRun, rdPend;
    logic countOverflow, countAtTop, waveOverflowEvent, capturePinEvent;
    logic forceCompareAStrobe, forceCompareBStrobe, compareBMatch, compareAMatch;
    logic [11:0] busAddr;
    logic [7:0]  busWdata, busRdata, m, eR;
    logic [3:0]  vectorAck, irqRequest, waveformModeBits;
    logic [2:0]  clockSel0, clockSel1, clockSel3, timerTick;
    logic [15:0] countValue, compareAValue, compareBValue, v;
    logic [7:0]  expQ[$];
    wire         extPin;
    wire  [2:0]  extCountPin = {extPin, 2'b00};
    int          nErrors, checkCount, ticks;
    int          sh[4] = '{3, 6, 8, 10};

    t3fp_timer_flags dut (.clk, .rstn, .busAddr, .busIoSpace, .busWrite, .busRead,
        .busWdata, .busRdata, .globalIrqEnable, .vectorAck, .irqRequest, .clockSel0,
        .clockSel1, .clockSel3, .extCountPin, .timerTick, .countValue, .compareAValue,
        .waveformModeBits, .countOverflow, .countAtTop, .waveOverflowEvent,
        .capturePinEvent, .forceCompareAStrobe, .forceCompareBStrobe, .compareBValue,
        .compareBMatch, .compareAMatch);
    t3fp_ext_src src (.clk(clk), .run(extRun), .pin(extPin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic acc(input logic [11:0] a, input logic io, input logic w,
                       input logic [7:0] d);
        busAddr = a;
        busIoSpace = io;
        busWdata = d;
        busWrite = w;
        busRead = !w;
        cyc(1);
        busWrite = 1'b0;
        busRead = 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [11:0] a, input logic io, input logic [7:0] e);
        expQ.push_back(e);
        acc(a, io, 1'b0, 8'h00);
    endtask
    task automatic completeRun();
        if (nErrors == 0 && checkCount > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Read data lands the cycle after the strobe
    always @(posedge clk) begin
        if (rdPend) begin
            eR = expQ.pop_front();
            `CHK("busRdata", eR, busRdata)
        end
        rdPend <= busRead;
    end
    always @(posedge clk) if (timerTick[2] === 1'b1) ticks++;
    initial begin
        #200000;
        nErrors++;
        completeRun();
    end

    initial begin
        {rstn, busIoSpace, busWrite, busRead, globalIrqEnable, extRun, rdPend} = '0;
        {countOverflow, countAtTop, waveOverflowEvent, capturePinEvent} = '0;
        {forceCompareAStrobe, forceCompareBStrobe, waveformModeBits, vectorAck} = '0;
        {busAddr, busWdata, clockSel0, clockSel1, clockSel3} = '0;
        compareAValue = 16'hFFFF;
        countValue = 16'h8000;
        void'($urandom(98));
        m = 8'($urandom);
        v = 16'($urandom_range(1, 16'h7FFF));
        repeat (5) @(posedge clk);
        #1 rstn = 1'b1;
        cyc(1);
        rd(12'h018, 1'b1, 8'h00);
        acc(12'h071, 1'b0, 1'b1, m);
        rd(12'h071, 1'b0, m & 8'h27);
        rd(12'h051, 1'b1, 8'h00);
        acc(12'h0A1, 1'b0, 1'b1, v[15:8]);
        `CHK("cmpB", 16'h0000, compareBValue)
        acc(12'h0A0, 1'b0, 1'b1, v[7:0]);
        `CHK("cmpB", v, compareBValue)
        {busAddr, busWdata, busWrite} = {12'h0A1, v[15:8], 1'b1};
        cyc(1);
        {busAddr, busWdata} = {12'h0A0, v[7:0]};
        cyc(1);
        busWrite = 1'b0;
        clockSel3 = 3'h1;
        {forceCompareAStrobe, forceCompareBStrobe} = 2'b11;
        cyc(1);
        `CHK("forced match", 2'h3, {compareAMatch, compareBMatch})
        {forceCompareAStrobe, forceCompareBStrobe} = 2'b00;
        rd(12'h018, 1'b1, 8'h00);
        countValue = v;
        cyc(1);
        `CHK("tick match", 2'h1, {compareAMatch, compareBMatch})
        countValue = 16'h8000;
        rd(12'h018, 1'b1, 8'h04);
        acc(12'h071, 1'b0, 1'b1, 8'h04);
        globalIrqEnable = 1'b1;
        cyc(1);
        `CHK("irq", 4'h4, irqRequest)
        acc(12'h071, 1'b0, 1'b1, 8'h23);
        `CHK("irq masked", 4'h0, irqRequest)
        globalIrqEnable = 1'b0;
        acc(12'h071, 1'b0, 1'b1, 8'h04);
        `CHK("irq", 4'h0, irqRequest)
        acc(12'h038, 1'b0, 1'b1, 8'h00);
        rd(12'h038, 1'b0, 8'h04);
        vectorAck = 4'b0100;
        cyc(1);
        vectorAck = 4'b0000;
        rd(12'h018, 1'b1, 8'h00);
        {countOverflow, capturePinEvent} = 2'b11;
        cyc(1);
        waveformModeBits = 4'h1;
        capturePinEvent = 1'b0;
        cyc(1);
        countOverflow = 1'b0;
        rd(12'h018, 1'b1, 8'h21);
        acc(12'h018, 1'b1, 1'b1, 8'h21);
        rd(12'h038, 1'b0, 8'h00);
        {waveformModeBits, capturePinEvent, waveOverflowEvent} = {4'hE, 2'h3};
        cyc(1);
        {capturePinEvent, waveOverflowEvent} = 2'h0;
        rd(12'h018, 1'b1, 8'h01);
        countAtTop = 1'b1;
        cyc(1);
        {countAtTop, waveformModeBits} = '0;
        rd(12'h018, 1'b1, 8'h21);
        {clockSel0, clockSel1} = 6'h09;
        ticks = 0;
        cyc(10);
        `CHK("sys ticks", 10, ticks)
        `CHK("all ticks", 3'h7, timerTick)
        for (int i = 0; i < 4; i++) begin
            clockSel3 = 3'h2 + 3'(i);
            ticks = 0;
            cyc(4 << sh[i]);
            `CHK("tap ticks", 4, ticks)
        end
        clockSel3 = 3'h0;
        ticks = 0;
        cyc(20);
        `CHK("stop ticks", 0, ticks)
        clockSel3 = 3'h2;
        acc(12'h023, 1'b1, 1'b1, 8'h01);
        ticks = 0;
        cyc(7);
        `CHK("psr gap", 0, ticks)
        cyc(1);
        `CHK("psr tick", 1, ticks)
        rd(12'h043, 1'b0, 8'h00);
        acc(12'h043, 1'b0, 1'b1, 8'h81);
        rd(12'h043, 1'b0, 8'h81);
        clockSel3 = 3'h1;
        ticks = 0;
        cyc(8);
        `CHK("held ticks", 0, ticks)
        `CHK("held all", 3'h0, timerTick)
        acc(12'h043, 1'b0, 1'b1, 8'h00);
        rd(12'h023, 1'b1, 8'h00);
        for (int i = 6; i < 8; i++) begin
            clockSel3 = 3'(i);
            ticks = 0;
            extRun = 1'b1;
            cyc(60);
            extRun = 1'b0;
            cyc(6);
            `CHK("ext ticks", 10, ticks)
        end
        cyc(2);
        completeRun();
    end
endmodule
